// file: logic/aax_adder.sv
// Purpose: 8-bit adder with carry-in and full status flag generation
// Assumes: Purely combinational, used by the datapath top
// Notes:   Zero flag comes from the shared zero-detect function
`timescale 1ns/1ps
module aax_adder
  import aax_pkg::*;
(
  input  wire logic [DATA_W-1:0] i_a,     // Accumulator operand
  input  wire logic [DATA_W-1:0] i_b,     // Memory operand
  input  wire logic              i_cin,   // Carry in
  output logic [DATA_W-1:0]      o_sum,   // Result byte
  output aax_flags_type          o_flags  // Flags of the result
);

  logic [DATA_W:0]     full_sum;
  logic [NIBBLE_W:0]   low_sum;

  always_comb begin
    full_sum = {1'b0, i_a} + {1'b0, i_b} + {{DATA_W{1'b0}}, i_cin};
    low_sum  = {1'b0, i_a[NIBBLE_W-1:0]} + {1'b0, i_b[NIBBLE_W-1:0]}
             + {{NIBBLE_W{1'b0}}, i_cin};
    o_sum    = full_sum[DATA_W-1:0];
    o_flags.c              = full_sum[DATA_W];
    o_flags.aux_carry_flag = low_sum[NIBBLE_W];
    // Same-sign operands giving a different-sign result
    o_flags.overflow_flag  = (i_a[SIGN_BIT] == i_b[SIGN_BIT])
                           && (o_sum[SIGN_BIT] != i_a[SIGN_BIT]);
    o_flags.signed_cond_flag = o_sum[SIGN_BIT] ^ o_flags.overflow_flag;
    o_flags.z              = aax_is_zero(o_sum);
  end

endmodule

// file: logic/aax_datapath.sv
// Purpose: Accumulator datapath for table read, XOR and extended ALU ops
// Assumes: Decoder supplies the operand byte with the op; one-cycle PM read
// Notes:   Table read takes three cycles; other ops finish in one
//
// Functional notes
// - Table read bumps pointer low, reads last page, low to memory, high to latch
// - XOR to accumulator: acc xor byte into acc, zero flag only
// - XOR to memory: acc xor byte back into byte, zero flag only
// - XOR immediate: acc xor immediate into acc, zero flag only
// - Extended forms address any data section directly, ignoring section select
// - Extended add with carry into acc, all five arithmetic flags updated
// - Extended add with carry into memory, all five arithmetic flags updated
// - Extended add without carry into acc, all five arithmetic flags updated
// - Extended add without carry into memory, all five arithmetic flags updated
// - Extended AND into acc, zero flag only
// - Extended AND into memory, zero flag only
// - Extended clear writes zero byte, flags unchanged
// - Extended bit clear zeroes one bit, others and flags unchanged
`timescale 1ns/1ps
module aax_datapath
  import aax_pkg::*;
(
  input  wire logic                 I_CLK,        // Core clock
  input  wire logic                 I_ARST_N,     // Async reset, low
  input  wire logic                 I_OP_VALID,   // Op offered
  input  wire aax_op_type           I_OP,         // Op and operands
  input  wire logic [SECT_W-1:0]    I_SECTION,    // Short-form section
  input  wire logic [PM_DATA_W-1:0] I_PM_DATA,    // Program word
  input  wire logic                 I_PTR_LOW_WE,    // Pointer low write
  input  wire logic [DATA_W-1:0]    I_PTR_LOW_WDATA, // Pointer low value
  output logic                      O_BUSY,       // Op not accepted
  output logic [DATA_W-1:0]         O_ACC,        // Accumulator
  output aax_flags_type             O_FLAGS,      // Status flags
  output logic [DATA_W-1:0]         O_PTR_LOW,    // Pointer low
  output logic [DATA_W-1:0]         O_TBL_HIGH,   // Table-high latch
  output logic                      O_MEM_WE,     // Data write pulse
  output logic [DM_ADDR_W-1:0]      O_MEM_ADDR,   // Data write address
  output logic [DATA_W-1:0]         O_MEM_WDATA,  // Data write byte
  output logic                      O_PM_RD,      // Program read pulse
  output logic [PM_ADDR_W-1:0]      O_PM_ADDR     // Program address
);

  //////////////////////////////////////////////////////////////////////////
  // Registers
  aax_state_type          state_reg,    state_next;
  logic [DATA_W-1:0]      acc_reg,      acc_next;
  aax_flags_type          flags_reg,    flags_next;
  logic [DATA_W-1:0]      ptr_low_reg,  ptr_low_next;
  logic [DATA_W-1:0]      tbl_high_reg, tbl_high_next;
  logic                   mem_we_reg,   mem_we_next;
  logic [DM_ADDR_W-1:0]   mem_addr_reg, mem_addr_next;
  logic [DATA_W-1:0]      mem_wdata_reg, mem_wdata_next;
  logic                   pm_rd_reg,    pm_rd_next;
  logic [PM_ADDR_W-1:0]   pm_addr_reg,  pm_addr_next;

  logic                   accept;
  logic                   add_cin;
  logic [DATA_W-1:0]      add_sum;
  aax_flags_type          add_flags;
  logic [DATA_W-1:0]      xor_res;
  logic [DATA_W-1:0]      and_res;
  logic [DATA_W-1:0]      ptr_low_inc;
  logic [DM_ADDR_W-1:0]   op_addr;

  //////////////////////////////////////////////////////////////////////////
  // Operand paths
  assign accept   = I_OP_VALID && (state_reg == AAX_ST_IDLE);
  assign xor_res  = acc_reg ^ I_OP.mem_data;
  assign and_res  = acc_reg & I_OP.mem_data;
  assign ptr_low_inc = ptr_low_reg + ONE_BYTE;
  // Carry feeds in only for the carry-add forms
  assign add_cin  = flags_reg.c && ((I_OP.opcode == AAX_EXT_ADD_CARRY_TO_ACC)
                 || (I_OP.opcode == AAX_EXT_ADD_CARRY_TO_MEM));
  // Extended forms bypass the section select
  assign op_addr  = aax_is_ext(I_OP.opcode) ? I_OP.addr
                  : {I_SECTION, I_OP.addr[DATA_W-1:0]};

  aax_adder u_adder (
    .i_a     (acc_reg),
    .i_b     (I_OP.mem_data),
    .i_cin   (add_cin),
    .o_sum   (add_sum),
    .o_flags (add_flags)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next     = state_reg;
    acc_next       = acc_reg;
    flags_next     = flags_reg;
    ptr_low_next   = ptr_low_reg;
    tbl_high_next  = tbl_high_reg;
    mem_we_next    = 1'b0;
    mem_addr_next  = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    pm_rd_next     = 1'b0;
    pm_addr_next   = pm_addr_reg;
    // Software pointer write only lands while no op runs or starts
    if (I_PTR_LOW_WE && (state_reg == AAX_ST_IDLE) && !accept) begin
      ptr_low_next = I_PTR_LOW_WDATA;
    end
    case (state_reg)
      AAX_ST_IDLE: begin
        if (accept) begin
          mem_addr_next = op_addr;
          case (I_OP.opcode)
            AAX_INC_TABLE_READ_LAST_PAGE: begin
              ptr_low_next = ptr_low_inc;
              pm_addr_next = {LAST_PAGE, ptr_low_inc};
              pm_rd_next   = 1'b1;
              state_next   = AAX_ST_TBL_WAIT;
            end
            AAX_XOR_TO_ACC_OP: begin
              acc_next     = xor_res;
              flags_next.z = aax_is_zero(xor_res);
            end
            AAX_XOR_TO_MEMORY_OP: begin
              mem_we_next    = 1'b1;
              mem_wdata_next = xor_res;
              flags_next.z   = aax_is_zero(xor_res);
            end
            AAX_XOR_IMM_OP: begin
              acc_next     = acc_reg ^ I_OP.imm;
              flags_next.z = aax_is_zero(acc_reg ^ I_OP.imm);
            end
            AAX_EXT_ADD_CARRY_TO_ACC, AAX_EXT_ADD_TO_ACC: begin
              acc_next   = add_sum;
              flags_next = add_flags;
            end
            AAX_EXT_ADD_CARRY_TO_MEM, AAX_EXT_ADD_TO_MEM: begin
              mem_we_next    = 1'b1;
              mem_wdata_next = add_sum;
              flags_next     = add_flags;
            end
            AAX_EXT_AND_TO_ACC: begin
              acc_next     = and_res;
              flags_next.z = aax_is_zero(and_res);
            end
            AAX_EXT_AND_TO_MEM: begin
              mem_we_next    = 1'b1;
              mem_wdata_next = and_res;
              flags_next.z   = aax_is_zero(and_res);
            end
            AAX_EXT_CLEAR_OP: begin
              mem_we_next    = 1'b1;
              mem_wdata_next = CLEAR_BYTE;
            end
            AAX_EXT_CLEAR_BIT_OP: begin
              mem_we_next    = 1'b1;
              mem_wdata_next = I_OP.mem_data & ~(BIT0_MASK << I_OP.bit_sel);
            end
            default: begin
              mem_addr_next = mem_addr_reg;
            end
          endcase
        end
      end
      AAX_ST_TBL_WAIT: begin
        state_next = AAX_ST_TBL_CAP;
      end
      AAX_ST_TBL_CAP: begin
        // Word arrives the cycle after the read strobe
        mem_we_next    = 1'b1;
        mem_wdata_next = I_PM_DATA[DATA_W-1:0];
        tbl_high_next  = I_PM_DATA[PM_DATA_W-1:DATA_W];
        state_next     = AAX_ST_IDLE;
      end
      default: begin
        state_next = AAX_ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg     <= AAX_ST_IDLE;
      acc_reg       <= ACC_RST;
      flags_reg     <= FLAGS_RST;
      ptr_low_reg   <= PTR_LOW_RST;
      tbl_high_reg  <= TBL_HIGH_RST;
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= '0;
      mem_wdata_reg <= CLEAR_BYTE;
      pm_rd_reg     <= 1'b0;
      pm_addr_reg   <= '0;
    end else begin
      state_reg     <= state_next;
      acc_reg       <= acc_next;
      flags_reg     <= flags_next;
      ptr_low_reg   <= ptr_low_next;
      tbl_high_reg  <= tbl_high_next;
      mem_we_reg    <= mem_we_next;
      mem_addr_reg  <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      pm_rd_reg     <= pm_rd_next;
      pm_addr_reg   <= pm_addr_next;
    end
  end

  assign O_BUSY      = (state_reg != AAX_ST_IDLE);
  assign O_ACC       = acc_reg;
  assign O_FLAGS     = flags_reg;
  assign O_PTR_LOW   = ptr_low_reg;
  assign O_TBL_HIGH  = tbl_high_reg;
  assign O_MEM_WE    = mem_we_reg;
  assign O_MEM_ADDR  = mem_addr_reg;
  assign O_MEM_WDATA = mem_wdata_reg;
  assign O_PM_RD     = pm_rd_reg;
  assign O_PM_ADDR   = pm_addr_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  logic acc_tbl;
  logic acc_xor_a;
  logic acc_xor_m;
  logic acc_xor_i;
  logic acc_adc_a;
  logic acc_add_m;
  logic acc_and_a;
  logic acc_clr;
  logic acc_clrb;
  logic acc_ext;
  assign acc_tbl   = accept && (I_OP.opcode == AAX_INC_TABLE_READ_LAST_PAGE);
  assign acc_xor_a = accept && (I_OP.opcode == AAX_XOR_TO_ACC_OP);
  assign acc_xor_m = accept && (I_OP.opcode == AAX_XOR_TO_MEMORY_OP);
  assign acc_xor_i = accept && (I_OP.opcode == AAX_XOR_IMM_OP);
  assign acc_adc_a = accept && (I_OP.opcode == AAX_EXT_ADD_CARRY_TO_ACC);
  assign acc_add_m = accept && (I_OP.opcode == AAX_EXT_ADD_TO_MEM);
  assign acc_and_a = accept && (I_OP.opcode == AAX_EXT_AND_TO_ACC);
  assign acc_clr   = accept && (I_OP.opcode == AAX_EXT_CLEAR_OP);
  assign acc_clrb  = accept && (I_OP.opcode == AAX_EXT_CLEAR_BIT_OP);
  assign acc_ext   = accept && aax_is_ext(I_OP.opcode);

  property p_tbl_seq;
    logic [DATA_W-1:0] p;
    (acc_tbl, p = ptr_low_reg) |=> (O_PTR_LOW == p + ONE_BYTE)
      && O_PM_RD && (O_PM_ADDR == {LAST_PAGE, O_PTR_LOW}) && O_BUSY;
  endproperty
  a_tbl_seq: assert property (p_tbl_seq) else $error("table read pointer or address wrong");

  property p_tbl_cap;
    O_PM_RD |=> ##1 O_MEM_WE && (O_MEM_WDATA == $past(I_PM_DATA[DATA_W-1:0]))
      && (O_TBL_HIGH == $past(I_PM_DATA[PM_DATA_W-1:DATA_W]))
      && (O_FLAGS == $past(O_FLAGS, 2)) && !O_BUSY;
  endproperty
  a_tbl_cap: assert property (p_tbl_cap) else $error("table read capture wrong");

  property p_xor_acc;
    acc_xor_a |=> (O_ACC == ($past(acc_reg) ^ $past(I_OP.mem_data)))
      && (O_FLAGS.z == (O_ACC == CLEAR_BYTE)) && !O_MEM_WE
      && (O_FLAGS.c == $past(flags_reg.c));
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor to acc wrong");

  property p_xor_mem;
    acc_xor_m |=> O_MEM_WE && (O_MEM_WDATA == ($past(acc_reg) ^ $past(I_OP.mem_data)))
      && $stable(O_ACC) && (O_FLAGS.overflow_flag == $past(flags_reg.overflow_flag));
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

  property p_xor_imm;
    acc_xor_i |=> (O_ACC == ($past(acc_reg) ^ $past(I_OP.imm)))
      && (O_FLAGS.z == (O_ACC == CLEAR_BYTE));
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

  property p_ext_addr;
    acc_ext |=> (O_MEM_ADDR == $past(I_OP.addr));
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("extended address not direct");

  property p_adc_acc;
    acc_adc_a |=> (O_ACC == DATA_W'($past(acc_reg) + $past(I_OP.mem_data)
      + {7'h00, $past(flags_reg.c)})) && (O_FLAGS.z == (O_ACC == CLEAR_BYTE));
  endproperty
  a_adc_acc: assert property (p_adc_acc) else $error("add with carry to acc wrong");

  property p_add_mem;
    acc_add_m |=> O_MEM_WE && (O_MEM_WDATA == DATA_W'($past(acc_reg) + $past(I_OP.mem_data)))
      && (O_FLAGS.c == (({1'b0, $past(acc_reg)} + {1'b0, $past(I_OP.mem_data)}) > 9'h0ff))
      && (O_FLAGS.signed_cond_flag == (O_MEM_WDATA[SIGN_BIT] ^ O_FLAGS.overflow_flag));
  endproperty
  a_add_mem: assert property (p_add_mem) else $error("add to memory wrong");

  property p_and_acc;
    acc_and_a |=> (O_ACC == ($past(acc_reg) & $past(I_OP.mem_data)))
      && (O_FLAGS.z == (O_ACC == CLEAR_BYTE));
  endproperty
  a_and_acc: assert property (p_and_acc) else $error("and to acc wrong");

  property p_clr;
    acc_clr |=> O_MEM_WE && (O_MEM_WDATA == CLEAR_BYTE) && $stable(O_FLAGS);
  endproperty
  a_clr: assert property (p_clr) else $error("byte clear wrong");

  property p_clrb;
    acc_clrb |=> O_MEM_WE && !O_MEM_WDATA[$past(I_OP.bit_sel)]
      && ((O_MEM_WDATA | (BIT0_MASK << $past(I_OP.bit_sel)))
          == ($past(I_OP.mem_data) | (BIT0_MASK << $past(I_OP.bit_sel))))
      && $stable(O_FLAGS);
  endproperty
  a_clrb: assert property (p_clrb) else $error("bit clear wrong");

endmodule

// file: shared/aax_pkg.sv
// Purpose: Shared constants and types for the accumulator ALU datapath
// Assumes: 8-bit data, 16-bit program words, sectioned data memory
// Notes:   Opcode codes are local to this block and the decoder
package aax_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned SECT_W     = 4;
  localparam int unsigned DM_ADDR_W  = SECT_W + DATA_W;
  localparam int unsigned PM_PAGE_W  = 5;
  localparam int unsigned PM_ADDR_W  = PM_PAGE_W + DATA_W;
  localparam int unsigned PM_DATA_W  = 16;

  // Last program page is the all-ones page
  localparam logic [PM_PAGE_W-1:0] LAST_PAGE   = 5'h1f;
  localparam logic [DATA_W-1:0]    ACC_RST     = 8'h00;
  localparam logic [DATA_W-1:0]    PTR_LOW_RST  = 8'h00;
  localparam logic [DATA_W-1:0]    TBL_HIGH_RST = 8'h00;
  localparam logic [DATA_W-1:0]    CLEAR_BYTE  = 8'h00;
  localparam logic [DATA_W-1:0]    BIT0_MASK   = 8'h01;
  localparam logic [DATA_W-1:0]    ONE_BYTE    = 8'h01;
  localparam int unsigned          SIGN_BIT    = 7;
  localparam int unsigned          NIBBLE_W    = 4;

  typedef enum logic [3:0] {
    AAX_NOP                     = 4'h0,
    AAX_INC_TABLE_READ_LAST_PAGE = 4'h1,
    AAX_XOR_TO_ACC_OP           = 4'h2,
    AAX_XOR_TO_MEMORY_OP        = 4'h3,
    AAX_XOR_IMM_OP              = 4'h4,
    AAX_EXT_ADD_CARRY_TO_ACC    = 4'h5,
    AAX_EXT_ADD_CARRY_TO_MEM    = 4'h6,
    AAX_EXT_ADD_TO_ACC          = 4'h7,
    AAX_EXT_ADD_TO_MEM          = 4'h8,
    AAX_EXT_AND_TO_ACC          = 4'h9,
    AAX_EXT_AND_TO_MEM          = 4'ha,
    AAX_EXT_CLEAR_OP            = 4'hb,
    AAX_EXT_CLEAR_BIT_OP        = 4'hc
  } aax_opcode_type;

  typedef enum logic [1:0] {
    AAX_ST_IDLE     = 2'b00,
    AAX_ST_TBL_WAIT = 2'b01,
    AAX_ST_TBL_CAP  = 2'b10
  } aax_state_type;

  typedef struct packed {
    aax_opcode_type          opcode;
    logic [DM_ADDR_W-1:0]    addr;
    logic [2:0]              bit_sel;
    logic [DATA_W-1:0]       imm;
    logic [DATA_W-1:0]       mem_data;
  } aax_op_type;

  typedef struct packed {
    logic overflow_flag;
    logic z;
    logic aux_carry_flag;
    logic c;
    logic signed_cond_flag;
  } aax_flags_type;

  localparam aax_flags_type FLAGS_RST = '{default: 1'b0};

  function automatic logic aax_is_zero(input logic [DATA_W-1:0] v);
    return (v == CLEAR_BYTE);
  endfunction

  function automatic logic aax_is_ext(input aax_opcode_type op);
    return (op >= AAX_EXT_ADD_CARRY_TO_ACC) && (op <= AAX_EXT_CLEAR_BIT_OP);
  endfunction

endpackage

// file: tb/aax_mem_model.sv
// Purpose: Data and program memory model facing the accumulator datapath
// Assumes: Program read answers one cycle after the read pulse
// Notes:   Program data toggles every cycle outside its answer window
`timescale 1ns/1ps
module aax_mem_model
  import aax_pkg::*;
(
  input  wire logic                 i_clk,       // Core clock
  input  wire logic                 i_arst_n,    // Async reset, low
  input  wire logic                 i_pm_rd,     // Program read pulse
  input  wire logic [PM_ADDR_W-1:0] i_pm_addr,   // Program address
  input  wire logic                 i_mem_we,    // Data write pulse
  input  wire logic [DM_ADDR_W-1:0] i_mem_addr,  // Data write address
  input  wire logic [DATA_W-1:0]    i_mem_wdata, // Data write byte
  output logic [PM_DATA_W-1:0]      o_pm_data    // Program word
);
  logic [DATA_W-1:0] dm [0:4095];

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 4096; i++) begin
      dm[i] = i[7:0] ^ {i[11:8], i[11:8]};
    end
  end

  always @(posedge i_clk) begin
    if (i_mem_we) begin
      dm[i_mem_addr] <= i_mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only the last page holds real words, so a wrong page shows up as junk
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pm_data <= 16'h0f0f;
    end else if (i_pm_rd) begin
      o_pm_data <= (i_pm_addr[12:8] == 5'h1f) ? {~i_pm_addr[7:0], i_pm_addr[7:0] ^ 8'h3c} : 16'hdead;
    end else begin
      o_pm_data <= ~o_pm_data;
    end
  end
endmodule

// file: tb/test_accumulator_alu_ext_ops.sv
// Purpose: Self-checking bench for the accumulator datapath
// Assumes: Reference values kept here, memory contents read from the model
// Notes:   Table rows first, then table reads, back-to-back and reset
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_accumulator_alu_ext_ops;
  import aax_pkg::*;
  typedef struct {aax_opcode_type op; logic [11:0] a; logic [2:0] b; logic [7:0] imm;} aax_row_type;
  logic i_clk = 0, i_arst_n = 0, i_op_valid = 0, i_ptr_low_we = 0, o_busy, o_mem_we, o_pm_rd;
  aax_op_type i_op = '0;
  logic [3:0] i_section = 4'h7;
  logic [7:0] i_ptr_low_wdata = 8'h00, o_acc, o_ptr_low, o_tbl_high, o_mem_wdata, exp_acc = 0, exp_wd;
  logic [15:0] i_pm_data;
  logic [11:0] o_mem_addr, exp_addr;
  logic [12:0] o_pm_addr;
  aax_flags_type o_flags, exp_flags = '0;
  logic exp_we;
  int bad_count = 0, compares = 0, cyc = 0;
  aax_op_type nx;
  aax_row_type rows [14] = '{
    '{AAX_XOR_IMM_OP, 12'h000, 3'h0, 8'h80}, '{AAX_EXT_ADD_TO_ACC, 12'h080, 3'h0, 8'h00},
    '{AAX_EXT_ADD_CARRY_TO_ACC, 12'h30f, 3'h0, 8'h00}, '{AAX_EXT_ADD_CARRY_TO_MEM, 12'h5a3, 3'h0, 8'h00},
    '{AAX_XOR_TO_MEMORY_OP, 12'h012, 3'h0, 8'h00}, '{AAX_XOR_TO_ACC_OP, 12'h012, 3'h0, 8'h00},
    '{AAX_EXT_ADD_TO_MEM, 12'hfff, 3'h0, 8'h00}, '{AAX_EXT_AND_TO_ACC, 12'h5a3, 3'h0, 8'h00},
    '{AAX_XOR_IMM_OP, 12'h000, 3'h0, 8'hc7}, '{AAX_EXT_AND_TO_MEM, 12'ha5c, 3'h0, 8'h00},
    '{AAX_EXT_CLEAR_BIT_OP, 12'ha5c, 3'h7, 8'h00}, '{AAX_EXT_CLEAR_OP, 12'h5a3, 3'h0, 8'h00},
    '{AAX_NOP, 12'h123, 3'h0, 8'hff}, '{AAX_EXT_ADD_CARRY_TO_ACC, 12'h7f0, 3'h0, 8'h00}};

  aax_datapath uut (.I_CLK(i_clk), .I_ARST_N(i_arst_n), .I_OP_VALID(i_op_valid), .I_OP(i_op),
    .I_SECTION(i_section), .I_PM_DATA(i_pm_data), .I_PTR_LOW_WE(i_ptr_low_we),
    .I_PTR_LOW_WDATA(i_ptr_low_wdata),
    .O_BUSY(o_busy), .O_ACC(o_acc), .O_FLAGS(o_flags), .O_PTR_LOW(o_ptr_low), .O_TBL_HIGH(o_tbl_high),
    .O_MEM_WE(o_mem_we), .O_MEM_ADDR(o_mem_addr), .O_MEM_WDATA(o_mem_wdata), .O_PM_RD(o_pm_rd),
    .O_PM_ADDR(o_pm_addr));
  aax_mem_model mdl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr),
    .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_pm_data(i_pm_data));

  ////////////////////////////////////////////////////////////////////////////
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      $display("[ERR] %0t run hung", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference result; memory operand is the model's current byte
  task automatic predict(input aax_row_type r, output aax_op_type o);
    logic [11:0] ea;
    logic [7:0] m, res;
    logic [8:0] s;
    logic [4:0] h;
    logic ci, ovf;
    ea = (r.op >= AAX_EXT_ADD_CARRY_TO_ACC) ? r.a : {i_section, r.a[7:0]};
    m = mdl.dm[ea];
    res = 8'h00;
    case (r.op)
      AAX_XOR_TO_ACC_OP, AAX_XOR_TO_MEMORY_OP: res = exp_acc ^ m;
      AAX_XOR_IMM_OP: res = exp_acc ^ r.imm;
      AAX_EXT_AND_TO_ACC, AAX_EXT_AND_TO_MEM: res = exp_acc & m;
      AAX_EXT_CLEAR_OP: res = 8'h00;
      AAX_EXT_CLEAR_BIT_OP: res = m & ~(8'h01 << r.b);
      AAX_NOP: res = 8'h00;
      default: begin
        ci = (r.op <= AAX_EXT_ADD_CARRY_TO_MEM) ? exp_flags.c : 1'b0;
        s = {1'b0, exp_acc} + {1'b0, m} + {8'h00, ci};
        h = {1'b0, exp_acc[3:0]} + {1'b0, m[3:0]} + {4'h0, ci};
        res = s[7:0];
        ovf = (exp_acc[7] == m[7]) && (res[7] != exp_acc[7]);
        exp_flags = '{ovf, res == 8'h00, h[4], s[8], res[7] ^ ovf};
      end
    endcase
    if (r.op inside {AAX_XOR_TO_ACC_OP, AAX_XOR_TO_MEMORY_OP, AAX_XOR_IMM_OP, AAX_EXT_AND_TO_ACC, AAX_EXT_AND_TO_MEM})
      exp_flags.z = (res == 8'h00);
    if (r.op inside {AAX_XOR_TO_ACC_OP, AAX_XOR_IMM_OP, AAX_EXT_ADD_CARRY_TO_ACC, AAX_EXT_ADD_TO_ACC, AAX_EXT_AND_TO_ACC})
      exp_acc = res;
    exp_we = r.op inside {AAX_XOR_TO_MEMORY_OP, AAX_EXT_ADD_CARRY_TO_MEM, AAX_EXT_ADD_TO_MEM,
                          AAX_EXT_AND_TO_MEM, AAX_EXT_CLEAR_OP, AAX_EXT_CLEAR_BIT_OP};
    exp_addr = ea;
    exp_wd = res;
    o = '{r.op, r.a, r.b, r.imm, m};
  endtask

  task automatic check_out();
    #1;
    `CHK(o_acc, exp_acc)
    `CHK(o_flags, exp_flags)
    `CHK(o_mem_we, exp_we)
    if (exp_we) begin
      `CHK(o_mem_addr, exp_addr)
      `CHK(o_mem_wdata, exp_wd)
    end
  endtask

  task automatic tbl_read(input logic [7:0] ptr, input logic [11:0] a);
    logic [7:0] np;
    np = ptr + 8'h01;
    @(posedge i_clk);
    i_ptr_low_we <= 1'b1;
    i_ptr_low_wdata <= ptr;
    @(posedge i_clk);
    i_ptr_low_we <= 1'b0;
    i_op_valid <= 1'b1;
    i_op <= '{AAX_INC_TABLE_READ_LAST_PAGE, a, 3'h0, 8'h00, 8'h00};
    #1 `CHK(o_ptr_low, ptr)
    @(posedge i_clk);
    // Refused op and pointer write while busy must leave no trace
    i_op <= '{AAX_XOR_IMM_OP, 12'h000, 3'h0, 8'hff, 8'h00};
    i_ptr_low_we <= 1'b1;
    i_ptr_low_wdata <= 8'h55;
    #1 `CHK({o_busy, o_pm_rd, o_pm_addr, o_ptr_low}, {2'b11, 5'h1f, np, np})
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    i_ptr_low_we <= 1'b0;
    @(posedge i_clk);
    #1 `CHK({o_mem_we, o_mem_addr, o_mem_wdata, o_tbl_high}, {1'b1, i_section, a[7:0], np ^ 8'h3c, ~np})
    `CHK({o_busy, o_acc, o_flags, o_ptr_low}, {1'b0, exp_acc, exp_flags, np})
    $display("table read from %h done", ptr);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_clk);
    #1 `CHK({o_busy, o_acc, o_flags, o_ptr_low, o_tbl_high, o_mem_we, o_pm_rd}, 32'h0)
    $display("reset hold done");
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    foreach (rows[k]) begin
      predict(rows[k], nx);
      @(posedge i_clk);
      i_op_valid <= 1'b1;
      i_op <= nx;
      @(posedge i_clk);
      i_op_valid <= 1'b0;
      check_out();
      // Let this row's data write land in the model before the next row reads the byte
      @(posedge i_clk);
      #1 $display("row %0d done", k);
    end
    tbl_read(8'hff, 12'h034);
    i_section <= 4'h2;
    tbl_read(8'h10, 12'h0c1);
    // Back-to-back accumulator ops, second depends on the first
    predict('{AAX_XOR_IMM_OP, 12'h000, 3'h0, 8'h3c}, nx);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= nx;
    @(posedge i_clk);
    predict('{AAX_EXT_ADD_TO_ACC, 12'h9e1, 3'h0, 8'h00}, nx);
    i_op <= nx;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    check_out();
    $display("back-to-back done");
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    #1 `CHK({o_acc, o_flags, o_ptr_low, o_tbl_high}, 29'h0)
    // Release again and run one op on the fresh state
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    exp_acc = ACC_RST;
    exp_flags = FLAGS_RST;
    predict('{AAX_XOR_IMM_OP, 12'h000, 3'h0, 8'h00}, nx);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= nx;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    check_out();
    $display("second reset done");
    report_and_stop();
  end
endmodule
